// >>> shared/tgpc_pkg.sv
// Shared constants and types of the timer global control block.
package tgpc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] TGPC_ADDR_GCTL = 8'h00;
  localparam logic [7:0] TGPC_ADDR_HCTL = 8'h04;
  localparam logic [7:0] TGPC_ADDR_UCNT = 8'h08;
  localparam logic [7:0] TGPC_ADDR_UPRD = 8'h0C;
  localparam logic [7:0] TGPC_ADDR_LCNT = 8'h10;
  localparam logic [7:0] TGPC_ADDR_LPRD = 8'h14;
  localparam logic [7:0] TGPC_ADDR_STAT = 8'h18;

  // ==========================================================================
  // Field positions of the global control register
  localparam int TGPC_GCTL_LO_RUN = 0;
  localparam int TGPC_GCTL_HI_RUN = 1;
  localparam int TGPC_GCTL_MODE_LSB = 2;
  localparam int TGPC_GCTL_PSC_PER_LSB = 8;
  localparam int TGPC_GCTL_PSC_CNT_LSB = 12;

  // ==========================================================================
  // Field positions of the half control register
  localparam int TGPC_HCTL_UP_EN_LSB = 0;
  localparam int TGPC_HCTL_LO_EN_LSB = 2;
  localparam int TGPC_HCTL_PIN_USE = 4;

  // ==========================================================================
  // Reset values and the word transfer size
  localparam logic [3:0] TGPC_PSC_RST = 4'h0;
  localparam logic [31:0] TGPC_WORD_RST = 32'h0000_0000;
  localparam logic [2:0] TGPC_HSIZE_WORD = 3'h2;

  // ==========================================================================
  // Operating modes and enable modes
  typedef enum logic [1:0] {
    TGPC_MODE_GP64 = 2'b00,
    TGPC_MODE_UNCH = 2'b01,
    TGPC_MODE_WDOG = 2'b10,
    TGPC_MODE_CHAIN = 2'b11
  } tgpc_mode_t;

  localparam logic [1:0] TGPC_EN_OFF = 2'h0;
  localparam logic [1:0] TGPC_EN_ONCE = 2'h1;

  // ==========================================================================
  // Bus slave states, Gray coded along idle, read wait, read done
  typedef enum logic [1:0] {
    TGPC_ST_IDLE = 2'b00,
    TGPC_ST_RWAIT = 2'b01,
    TGPC_ST_RDONE = 2'b11,
    TGPC_ST_WR = 2'b10
  } tgpc_bus_state_t;

endpackage

// >>> core/tgpc_ahb_slave.sv
// AHB-Lite slave front end of the timer global control block.
`timescale 1ns/1ns
module tgpc_ahb_slave
  import tgpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data
);

  typedef struct packed {
    tgpc_bus_state_t st;
    logic [7:0] addr;
    logic [31:0] rdata;
  } tgpc_bus_reg_t;

  tgpc_bus_reg_t s_reg;
  tgpc_bus_reg_t s_next;
  logic take;

  // ==========================================================================
  // Address phase capture; reads add one wait state so writes just made show.
  always_comb
  begin
    s_next = s_reg;
    take = hsel && htrans[1] && hready;
    case (s_reg.st)
      TGPC_ST_RWAIT:
      begin
        s_next.rdata = rd_data;
        s_next.st = TGPC_ST_RDONE;
      end
      TGPC_ST_IDLE, TGPC_ST_RDONE, TGPC_ST_WR:
      begin
        s_next.st = TGPC_ST_IDLE;
        if (take)
        begin
          s_next.addr = haddr[7:0];
          if (!hwrite)
            s_next.st = TGPC_ST_RWAIT;
          else if (hsize == TGPC_HSIZE_WORD)
            s_next.st = TGPC_ST_WR;
        end
      end
      default: s_next.st = TGPC_ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_reg <= '{TGPC_ST_IDLE, 8'h00, TGPC_WORD_RST};
    else
      s_reg <= s_next;
  end

  // Bus answers and the write strobe of the data phase.
  assign hreadyout = (s_reg.st != TGPC_ST_RWAIT);
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign wr_en = (s_reg.st == TGPC_ST_WR);
  assign wr_addr = s_reg.addr;
  assign wr_data = hwdata;
  assign rd_addr = s_reg.addr;

endmodule

// >>> core/tgpc_upper_half.sv
// Upper 32-bit half: prescale counter and upper count register.
`timescale 1ns/1ns
module tgpc_upper_half
  import tgpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic unchained,
  input wire logic carry_in,
  input wire logic [1:0] en_mode,
  input wire logic [3:0] psc_period,
  input wire logic [31:0] period,
  input wire logic cnt_wr,
  input wire logic [31:0] cnt_wdata,
  output logic [3:0] psc_count,
  output logic [31:0] count,
  output logic status,
  output logic oneshot_done
);

  typedef struct packed {
    logic [3:0] psc;
    logic tick;
    logic [31:0] cnt;
    logic stat;
  } tgpc_upper_reg_t;

  tgpc_upper_reg_t u_reg;
  tgpc_upper_reg_t u_next;
  logic en;
  logic adv;
  logic done;

  // ==========================================================================
  // Prescaler paces the count in unchained mode; other modes use the carry.
  always_comb
  begin
    u_next = u_reg;
    en = run && (en_mode != TGPC_EN_OFF);
    adv = unchained ? u_reg.tick : carry_in;
    done = en && (en_mode == TGPC_EN_ONCE) && (u_reg.cnt == period);
    if (!run)
    begin
      u_next.psc = TGPC_PSC_RST;
      u_next.tick = 1'b0;
      u_next.stat = 1'b0;
    end
    else if (en && unchained)
    begin
      u_next.psc = (u_reg.psc == psc_period) ? TGPC_PSC_RST : u_reg.psc + 4'h1;
      u_next.tick = (u_reg.psc == psc_period);
      u_next.stat = (u_reg.cnt == period);
    end
    else
    begin
      u_next.psc = TGPC_PSC_RST;
      u_next.tick = 1'b0;
      u_next.stat = en && (u_reg.cnt == period);
    end
    if (en && adv && !done)
      u_next.cnt = (u_reg.cnt == period) ? TGPC_WORD_RST : u_reg.cnt + 32'h1;
    if (cnt_wr)
      u_next.cnt = cnt_wdata;
  end

  // State register; the count keeps its value through a half reset.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      u_reg <= '{TGPC_PSC_RST, 1'b0, TGPC_WORD_RST, 1'b0};
    else
      u_reg <= u_next;
  end

  assign psc_count = u_reg.psc;
  assign count = u_reg.cnt;
  assign status = u_reg.stat;
  assign oneshot_done = done;

  // ==========================================================================
  // Checks of the upper half.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_psc_match;
    run && unchained && en && (u_reg.psc == psc_period);
  endsequence

  a_psc_advance: assert property (
    run && unchained && en && (u_reg.psc != psc_period)
    |=> u_reg.psc == $past(u_reg.psc) + 4'h1)
    else $error("prescaler did not step");
  a_psc_wrap: assert property (s_psc_match |=> u_reg.psc == 4'h0)
    else $error("prescaler did not wrap");
  a_cnt_step: assert property (
    s_psc_match ##1 (run && unchained && en && !cnt_wr && !done && (u_reg.cnt != period))
    |=> u_reg.cnt == $past(u_reg.cnt) + 32'h1)
    else $error("count did not follow prescale match");
  a_cont_wrap: assert property (
    en && adv && !done && !cnt_wr && (u_reg.cnt == period)
    |=> u_reg.cnt == 32'h0)
    else $error("count did not wrap");
  a_hold_reset: assert property (
    !run && !cnt_wr
    |=> !status && psc_count == 4'h0 && $stable(u_reg.cnt))
    else $error("upper half not held");
endmodule

// >>> core/tgpc_top.sv
// Timer global control: mode decode, half run controls, upper prescaler.
//
// Behaviour
// - Global control bits 31..16 read as zero; writes to them are ignored.
// - Global control bits 7..4 are read-only and read as zero.
// - A 4-bit upper prescale counter exists for unchained mode, zero after reset.
// - While the upper half is enabled in unchained mode, the prescale counter steps every cycle; other modes hold it at zero.
// - Upper count steps on the cycle after prescale counter equals prescale period.
// - After reaching the prescale period, the prescale counter restarts from zero.
// - In single-run mode the upper half stops when count equals period.
// - In continuous mode the upper count clears the cycle after matching period.
// - A 4-bit writable upper prescale period, zero after reset, for unchained mode.
// - Mode 00b means 64-bit general purpose; mode 10b means 64-bit watchdog.
// - Mode 01b runs two independent halves; mode 11b runs two chained halves.
// - While the watchdog is active, run bit changes have no effect.
// - Upper run bit zero holds upper half reset, clears status, keeps count.
// - Lower run bit zero clears status, floats the pin, keeps count.
// - Upper run bit one releases the upper half to operate.
// - Lower run bit one releases the lower half to operate.
// - The lower pin follows the lower output status when used as timer output.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
module tgpc_top
  import tgpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wdog_active,
  output logic mode_gp64,
  output logic mode_dual_unchained,
  output logic mode_wdog64,
  output logic mode_dual_chained,
  output logic upper_half_run,
  output logic lower_half_run,
  output logic upper_output_status,
  output logic lower_output_status,
  output logic lower_timer_pin_out,
  output logic lower_timer_pin_oe
);

  // ==========================================================================
  // State of the block
  typedef struct packed {
    logic [3:0] psc_per;
    tgpc_mode_t mode;
    logic hi_run;
    logic lo_run;
    logic [1:0] up_en;
    logic [1:0] lo_en;
    logic pin_use;
    logic [31:0] up_prd;
    logic [31:0] lo_cnt;
    logic [31:0] lo_prd;
    logic lo_stat;
  } tgpc_main_reg_t;

  tgpc_main_reg_t m_reg;
  tgpc_main_reg_t m_next;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [3:0] up_psc;
  logic [31:0] up_cnt;
  logic up_stat;
  logic up_done;
  logic up_cnt_wr;
  logic lo_on;
  logic lo_done;
  logic lo_carry;
  logic unch;

  // ==========================================================================
  // Bus slave
  tgpc_ahb_slave u_bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ==========================================================================
  // Upper half
  tgpc_upper_half u_upper (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(m_reg.hi_run),
    .unchained(unch),
    .carry_in(lo_carry),
    .en_mode(m_reg.up_en),
    .psc_period(m_reg.psc_per),
    .period(m_reg.up_prd),
    .cnt_wr(up_cnt_wr),
    .cnt_wdata(wr_data),
    .psc_count(up_psc),
    .count(up_cnt),
    .status(up_stat),
    .oneshot_done(up_done)
  );

  // ==========================================================================
  // Lower half control terms; its carry paces the upper half when chained.
  assign unch = (m_reg.mode == TGPC_MODE_UNCH);
  assign lo_on = m_reg.lo_run && (m_reg.lo_en != TGPC_EN_OFF);
  assign lo_done = lo_on && (m_reg.lo_en == TGPC_EN_ONCE) && (m_reg.lo_cnt == m_reg.lo_prd);
  assign lo_carry = lo_on && !lo_done && (m_reg.lo_cnt == m_reg.lo_prd);
  assign up_cnt_wr = wr_en && (wr_addr == TGPC_ADDR_UCNT);

  // ==========================================================================
  // Next state: lower counting, one-shot stops, then software writes.
  always_comb
  begin
    m_next = m_reg;
    if (!m_reg.lo_run)
      m_next.lo_stat = 1'b0;
    else
      m_next.lo_stat = lo_on && (m_reg.lo_cnt == m_reg.lo_prd);
    if (lo_on && !lo_done)
      m_next.lo_cnt = lo_carry ? TGPC_WORD_RST : m_reg.lo_cnt + 32'h1;
    if (lo_done)
      m_next.lo_en = TGPC_EN_OFF;
    if (up_done)
      m_next.up_en = TGPC_EN_OFF;
    if (wr_en)
    begin
      case (wr_addr)
        TGPC_ADDR_GCTL:
        begin
          m_next.psc_per = wr_data[TGPC_GCTL_PSC_PER_LSB +: 4];
          m_next.mode = tgpc_mode_t'(wr_data[TGPC_GCTL_MODE_LSB +: 2]);
          if (!wdog_active)
          begin
            m_next.hi_run = wr_data[TGPC_GCTL_HI_RUN];
            m_next.lo_run = wr_data[TGPC_GCTL_LO_RUN];
          end
        end
        TGPC_ADDR_HCTL:
        begin
          m_next.up_en = wr_data[TGPC_HCTL_UP_EN_LSB +: 2];
          m_next.lo_en = wr_data[TGPC_HCTL_LO_EN_LSB +: 2];
          m_next.pin_use = wr_data[TGPC_HCTL_PIN_USE];
        end
        TGPC_ADDR_UPRD: m_next.up_prd = wr_data;
        TGPC_ADDR_LCNT: m_next.lo_cnt = wr_data;
        TGPC_ADDR_LPRD: m_next.lo_prd = wr_data;
        default: m_next.lo_prd = m_next.lo_prd;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      m_reg <= '{TGPC_PSC_RST, TGPC_MODE_GP64, 1'b0, 1'b0, TGPC_EN_OFF, TGPC_EN_OFF,
        1'b0, TGPC_WORD_RST, TGPC_WORD_RST, TGPC_WORD_RST, 1'b0};
    end
    else
      m_reg <= m_next;
  end

  // ==========================================================================
  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_data = TGPC_WORD_RST;
    case (rd_addr)
      TGPC_ADDR_GCTL:
        rd_data = {16'h0000, up_psc, m_reg.psc_per, 4'h0, m_reg.mode,
          m_reg.hi_run, m_reg.lo_run};
      TGPC_ADDR_HCTL: rd_data = {27'h0, m_reg.pin_use, m_reg.lo_en, m_reg.up_en};
      TGPC_ADDR_UCNT: rd_data = up_cnt;
      TGPC_ADDR_UPRD: rd_data = m_reg.up_prd;
      TGPC_ADDR_LCNT: rd_data = m_reg.lo_cnt;
      TGPC_ADDR_LPRD: rd_data = m_reg.lo_prd;
      TGPC_ADDR_STAT: rd_data = {30'h0, up_stat, m_reg.lo_stat};
      default: rd_data = TGPC_WORD_RST;
    endcase
  end

  // ==========================================================================
  // Mode decode, run levels, status and the lower pin.
  assign mode_gp64 = (m_reg.mode == TGPC_MODE_GP64);
  assign mode_wdog64 = (m_reg.mode == TGPC_MODE_WDOG);
  assign mode_dual_unchained = unch;
  assign mode_dual_chained = (m_reg.mode == TGPC_MODE_CHAIN);
  assign upper_half_run = m_reg.hi_run;
  assign lower_half_run = m_reg.lo_run;
  assign upper_output_status = up_stat;
  assign lower_output_status = m_reg.lo_stat;
  assign lower_timer_pin_out = m_reg.lo_stat;
  assign lower_timer_pin_oe = m_reg.lo_run && m_reg.pin_use;

  // ==========================================================================
  // Checks of the global control.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_lo_go;
    lo_on && !lo_done && (m_reg.lo_cnt != m_reg.lo_prd)
      && !(wr_en && wr_addr == TGPC_ADDR_LCNT);
  endsequence

  a_gctl_high_zero: assert property (
    rd_addr == TGPC_ADDR_GCTL |-> rd_data[31:16] == 16'h0)
    else $error("global control high half not zero");
  a_gctl_rsvd_zero: assert property (
    rd_addr == TGPC_ADDR_GCTL |-> rd_data[7:4] == 4'h0)
    else $error("global control reserved bits not zero");
  a_mode_wide: assert property (
    wr_en && wr_addr == TGPC_ADDR_GCTL && wr_data[3:2] == 2'b10
    |=> mode_wdog64 && !mode_gp64)
    else $error("watchdog mode not decoded");
  a_mode_dual: assert property (
    wr_en && wr_addr == TGPC_ADDR_GCTL && wr_data[3:2] == 2'b01
    |=> mode_dual_unchained && !mode_dual_chained)
    else $error("unchained mode not decoded");
  a_run_locked: assert property (
    wdog_active |=> $stable(upper_half_run) && $stable(lower_half_run))
    else $error("run bit moved under watchdog");
  // A run bit written in the same cycle may release the pin, so the enable is
  // judged against the run level that follows.
  a_lower_reset: assert property (
    !m_reg.lo_run && !(wr_en && wr_addr == TGPC_ADDR_LCNT)
    |=> !lower_output_status && $stable(m_reg.lo_cnt)
    && (lower_half_run || !lower_timer_pin_oe))
    else $error("lower half not held in reset");
  a_lower_step: assert property (
    s_lo_go |=> m_reg.lo_cnt == $past(m_reg.lo_cnt) + 32'h1)
    else $error("lower count did not step");
  a_pin_follow: assert property (
    lower_timer_pin_oe |-> lower_timer_pin_out == lower_output_status
    && lower_timer_pin_out == $past(lo_on && (m_reg.lo_cnt == m_reg.lo_prd)))
    else $error("lower pin not from status");
  a_upper_stop: assert property (
    up_done && !(wr_en && wr_addr == TGPC_ADDR_HCTL)
    |=> m_reg.up_en == TGPC_EN_OFF)
    else $error("single run did not stop");

endmodule

// >>> dv/test_tgpc_top.sv
// Self-checking testbench of the timer global control block over AHB-Lite.
`timescale 1ns/1ns
`define tb_chk(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("FAIL %s expected %0h seen %0h", name, exp, got); end end
module test_tgpc_top
  import tgpc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic wdog_active = 1'b0;
  wire logic hready;
  logic hreadyout, hresp, mode_gp64, mode_dual_unchained, mode_wdog64, mode_dual_chained;
  logic upper_half_run, lower_half_run, upper_output_status, lower_output_status;
  logic lower_timer_pin_out, lower_timer_pin_oe;
  logic [31:0] hrdata, a, b;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  // ==========================================================================
  // Clock, single slave ready loop and design instance.
  always #4 sys_clk = ~sys_clk;
  assign hready = hreadyout;

  tgpc_top dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wdog_active(wdog_active), .mode_gp64(mode_gp64),
    .mode_dual_unchained(mode_dual_unchained), .mode_wdog64(mode_wdog64),
    .mode_dual_chained(mode_dual_chained), .upper_half_run(upper_half_run),
    .lower_half_run(lower_half_run), .upper_output_status(upper_output_status),
    .lower_output_status(lower_output_status), .lower_timer_pin_out(lower_timer_pin_out),
    .lower_timer_pin_oe(lower_timer_pin_oe));

  // ==========================================================================
  // Verdict and end of the run.
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  // ==========================================================================
  // One single word transfer; ready and read data are taken at the rising edge.
  // Waits are unbounded here; the cycle ceiling ends a hung transfer.
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= TGPC_HSIZE_WORD;
    do
    begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge sys_clk);
      `tb_chk("hresp", 1'b0, hresp)
    end while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Write and read wrappers around the transfer.
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, adr, wd, dummy);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] rd_val);
    bus(1'b0, adr, 32'h0000_0000, rd_val);
  endtask

  // Lets register updates reach the level outputs.
  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values.
    rd(TGPC_ADDR_GCTL, a);
    `tb_chk("gctl_rst", 32'h0000_0000, a)
    `tb_chk("modes_rst", 4'h8, {mode_gp64, mode_dual_unchained, mode_wdog64, mode_dual_chained})
    `tb_chk("oe_rst", 1'b0, lower_timer_pin_oe)
    // Reserved and read-only bits, unmapped offset.
    wr(TGPC_ADDR_GCTL, 32'hFFFF_FFF0);
    rd(TGPC_ADDR_GCTL, a);
    `tb_chk("gctl_resv", 32'h0000_0F00, a)
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, a);
    `tb_chk("unmapped", 32'h0000_0000, a)
    // Every operating mode.
    for (int m = 0; m < 4; m++)
    begin
      wr(TGPC_ADDR_GCTL, 32'(m) << 2);
      settle();
      a[3:0] = {mode_gp64, mode_dual_unchained, mode_wdog64, mode_dual_chained};
      `tb_chk("mode", 4'h8 >> m, a[3:0])
    end
    // Run bits frozen while the watchdog is active, mode still written.
    wr(TGPC_ADDR_GCTL, 32'h0000_0003);
    wdog_active <= 1'b1;
    wr(TGPC_ADDR_GCTL, 32'h0000_000C);
    settle();
    `tb_chk("wd_runs", 2'h3, {upper_half_run, lower_half_run})
    rd(TGPC_ADDR_GCTL, a);
    `tb_chk("wd_gctl", 32'h0000_000F, a)
    wdog_active <= 1'b0;
    // Upper half in unchained mode, prescale period 2: one step every three cycles.
    wr(TGPC_ADDR_HCTL, 32'h0000_0000);
    wr(TGPC_ADDR_UCNT, 32'h0000_0000);
    wr(TGPC_ADDR_UPRD, 32'hFFFF_FFFF);
    wr(TGPC_ADDR_GCTL, 32'h0000_0206);
    wr(TGPC_ADDR_HCTL, 32'h0000_0002);
    rd(TGPC_ADDR_UCNT, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_UCNT, b);
    `tb_chk("psc_steps", 32'h0000_0004, b - a)
    rd(TGPC_ADDR_GCTL, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_GCTL, b);
    `tb_chk("psc_phase", a[15:12], b[15:12])
    `tb_chk("psc_range", 1'b1, a[15:12] <= 4'h2)
    // Upper run bit off: count kept, prescaler held at zero.
    wr(TGPC_ADDR_GCTL, 32'h0000_0204);
    rd(TGPC_ADDR_UCNT, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_UCNT, b);
    `tb_chk("ucnt_keep", a, b)
    rd(TGPC_ADDR_GCTL, a);
    `tb_chk("psc_held", 4'h0, a[15:12])
    // Upper status high at count equal period, cleared by the run bit.
    wr(TGPC_ADDR_UCNT, 32'h0000_0000);
    wr(TGPC_ADDR_UPRD, 32'h0000_0000);
    wr(TGPC_ADDR_GCTL, 32'h0000_0206);
    settle();
    `tb_chk("ustat_on", 1'b1, upper_output_status)
    wr(TGPC_ADDR_GCTL, 32'h0000_0204);
    settle();
    `tb_chk("ustat_off", 1'b0, upper_output_status)
    // Continuous run, period 5: six-cycle wrap seen twelve cycles apart.
    wr(TGPC_ADDR_UPRD, 32'h0000_0005);
    wr(TGPC_ADDR_GCTL, 32'h0000_0006);
    rd(TGPC_ADDR_UCNT, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_UCNT, b);
    `tb_chk("wrap_same", a, b)
    `tb_chk("wrap_range", 1'b1, a <= 32'h0000_0005)
    // Single run stops at the period and clears its enable.
    wr(TGPC_ADDR_HCTL, 32'h0000_0000);
    wr(TGPC_ADDR_UCNT, 32'h0000_0000);
    wr(TGPC_ADDR_UPRD, 32'h0000_0003);
    wr(TGPC_ADDR_HCTL, 32'h0000_0001);
    repeat (30) @(posedge sys_clk);
    rd(TGPC_ADDR_UCNT, a);
    `tb_chk("once_stop", 32'h0000_0003, a)
    rd(TGPC_ADDR_HCTL, a);
    `tb_chk("once_en", 2'h0, a[1:0])
    // Lower half drives the pin from its status; run bit off floats it.
    wr(TGPC_ADDR_LCNT, 32'h0000_0000);
    wr(TGPC_ADDR_LPRD, 32'h0000_0000);
    wr(TGPC_ADDR_GCTL, 32'h0000_0005);
    wr(TGPC_ADDR_HCTL, 32'h0000_001C);
    settle();
    `tb_chk("lstat_on", 1'b1, lower_output_status)
    `tb_chk("pin_out", 2'h3, {lower_timer_pin_out, lower_timer_pin_oe})
    wr(TGPC_ADDR_LPRD, 32'hFFFF_FFFF);
    wr(TGPC_ADDR_GCTL, 32'h0000_0004);
    settle();
    `tb_chk("lstat_off", 2'h0, {lower_output_status, lower_timer_pin_oe})
    rd(TGPC_ADDR_LCNT, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_LCNT, b);
    `tb_chk("lcnt_keep", a, b)
    // Chained mode: the upper count steps once per lower wrap, lower period 2.
    wr(TGPC_ADDR_LCNT, 32'h0000_0000);
    wr(TGPC_ADDR_LPRD, 32'h0000_0002);
    wr(TGPC_ADDR_UCNT, 32'h0000_0000);
    wr(TGPC_ADDR_UPRD, 32'hFFFF_FFFF);
    wr(TGPC_ADDR_GCTL, 32'h0000_000F);
    wr(TGPC_ADDR_HCTL, 32'h0000_000A);
    rd(TGPC_ADDR_UCNT, a);
    repeat (8) @(posedge sys_clk);
    rd(TGPC_ADDR_UCNT, b);
    `tb_chk("chain_steps", 32'h0000_0004, b - a)
    final_report();
  end
endmodule
